/* File: core/issrt_pkg.sv */
// Shared constants and types of the two-wire slave receive/transmit path.
// Assumes the bus pins are sampled into the clk_sys domain before use.
// Behaviour
// - Matched address with direction zero: clear direction bit, buffer it, acknowledge.
// - Withhold address acknowledge while buffer full or receive overflow is set.
// - Raise the port interrupt flag per byte; only software clears it.
// - Receive stretch on, ninth fall of data byte, buffer full: clear release bit.
// - Buffer read before the ninth fall: release bit untouched, no stretch.
// - Matched read address: set direction bit, buffer it, acknowledge, hold clock.
// - Software write of transmit data also loads the transmit shift register.
// - Transmit eight bits, changing data on each falling clock edge.
// - Master acknowledges on the ninth clock; capture it at its rising edge.
// - Not-acknowledge after sent byte: end transfer, reset status, await Start.
// - In transmit, raise the interrupt flag at the ninth falling edge.
// - Transmit, ninth fall, buffer empty: clear release bit whatever stretch setting.
// - Buffer loaded before the ninth fall: no release bit clear, no stretch.
// - Ten-bit address with update flag: stretch, keep release bit, free on rewrite.
// - Set update flag after high address byte and after low write byte.
// - Buffer-full stretching applies to data bytes only, never address bytes.
// - Ten-bit read address: leave update flag clear, transmit, stretch as seven-bit.
// - Pull clock low only after the clock line was already sampled low.
// - Keep clock low until release bit set; then the wired line rises.
package issrt_pkg;

  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam logic [3:0] CNT_FIRST = 4'h0;
  localparam logic [3:0] CNT_LAST_DATA = 4'h8;
  localparam logic [3:0] CNT_NINTH = 4'h9;
  localparam logic CKP_RESET = 1'b1;
  localparam logic [7:0] BUF_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'hff;

  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR1, PH_ADDR2, PH_RX, PH_TX, PH_IGNORE
  } issrt_phase_type;

  typedef struct packed {
    logic addr_wr;
    logic buf_wr;
    logic buf_rd;
    logic ckp_set;
    logic irq_clr;
    logic ov_clr;
  } issrt_cmd_type;

  typedef struct packed {
    logic rw_status;
    logic update_address_flag;
    logic buffer_full_flag;
    logic receive_overflow_flag;
    logic port_irq_flag;
    logic clock_release_bit;
  } issrt_status_type;

  typedef struct packed {
    logic out;
    logic oe;
  } issrt_od_type;

  typedef struct packed {
    issrt_phase_type phase;
    logic [3:0] cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [7:0] buf_q;
    logic ack_drive;
    logic ua_hold;
    logic hi_matched;
    logic was_data;
    logic nacked;
    logic scl_hold;
    logic sda_hold;
    issrt_status_type st;
  } issrt_state_type;

  localparam issrt_status_type STATUS_RESET = '{
    rw_status: 1'b0, update_address_flag: 1'b0, buffer_full_flag: 1'b0,
    receive_overflow_flag: 1'b0, port_irq_flag: 1'b0,
    clock_release_bit: CKP_RESET};

  localparam issrt_state_type STATE_RESET = '{
    phase: PH_IDLE, cnt: CNT_FIRST, rx_shift: BUF_RESET,
    tx_shift: SHIFT_RESET, buf_q: BUF_RESET, ack_drive: 1'b0,
    ua_hold: 1'b0, hi_matched: 1'b0, was_data: 1'b0, nacked: 1'b0,
    scl_hold: 1'b0, sda_hold: 1'b0, st: STATUS_RESET};

endpackage

/* File: core/issrt_sync.sv */
// Two-flop synchroniser for levels that come from outside clk_sys.
// Assumes the inputs are quasi-static against the system clock.
`timescale 1ns/1ps
module issrt_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } issrt_sync_state_type;

  issrt_sync_state_type s_reg;
  issrt_sync_state_type s_next;

  // Idle bus lines are high, so reset to ones.
  always_comb begin
    s_next.meta = async_in;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_reg <= '1;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.stable;

endmodule

/* File: core/issrt_edge.sv */
// Edge and Start/Stop detector on the synchronised clock and data lines.
// Assumes both inputs already come from flip-flops on clk_sys.
`timescale 1ns/1ps
module issrt_edge (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic scl_s,
  input wire logic sda_s,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen
);

  typedef struct packed {
    logic scl_d;
    logic sda_d;
  } issrt_edge_state_type;

  issrt_edge_state_type s_reg;
  issrt_edge_state_type s_next;

  always_comb begin
    s_next.scl_d = scl_s;
    s_next.sda_d = sda_s;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_reg <= '1;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign scl_rise = !s_reg.scl_d && scl_s;
  assign scl_fall = s_reg.scl_d && !scl_s;
  // Data moving while the clock stays high marks Start or Stop.
  assign start_seen = s_reg.scl_d && scl_s && s_reg.sda_d && !sda_s;
  assign stop_seen = s_reg.scl_d && scl_s && !s_reg.sda_d && sda_s;

endmodule

/* File: core/issrt_slave.sv */
// Slave data path of a two-wire port: address, receive, transmit, stretch.
// Assumes software drives sw_cmd as one-cycle pulses on clk_sys and that
// the pins reach this block through open-drain pads with pull-ups.
`timescale 1ns/1ps
module issrt_slave
  import issrt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output issrt_od_type scl_drive,
  output issrt_od_type sda_drive,
  input wire logic ten_bit_mode,
  input wire logic receive_stretch_enable,
  input wire logic [7:0] own_address_register,
  input wire logic [7:0] transfer_wdata,
  input wire issrt_cmd_type sw_cmd,
  output logic [7:0] transfer_buffer,
  output issrt_status_type port_status_register
);

  issrt_state_type s_reg;
  issrt_state_type s_next;

  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic live;
  logic byte_end;
  logic ninth_end;
  logic match7;
  logic prefix_ok;
  logic addr_ok;
  logic full;
  logic hold_req;

  issrt_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in({scl_pin, sda_pin}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  issrt_edge u_edge (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  assign live = s_reg.phase != PH_IDLE && s_reg.phase != PH_IGNORE;
  assign byte_end = clk_en && live && scl_fall && !start_seen &&
    s_reg.cnt == CNT_LAST_DATA;
  assign ninth_end = clk_en && live && scl_fall && s_reg.cnt == CNT_NINTH;
  assign match7 = s_reg.rx_shift[7:1] == own_address_register[7:1];
  assign prefix_ok = s_reg.rx_shift[7:3] == TEN_BIT_PREFIX;
  // A ten-bit read address only counts after the full address matched.
  assign addr_ok = match7 && (!ten_bit_mode || prefix_ok) &&
    (!s_reg.rx_shift[0] || !ten_bit_mode || s_reg.hi_matched);
  assign full = s_reg.st.buffer_full_flag || s_reg.st.receive_overflow_flag;

  always_comb begin
    s_next = s_reg;
    hold_req = 1'b0;
    // Software side effects except ckp_set come first so that bus events override them.
    if (sw_cmd.addr_wr) begin
      s_next.st.update_address_flag = 1'b0;
      s_next.ua_hold = 1'b0;
    end
    if (sw_cmd.buf_rd) begin
      s_next.st.buffer_full_flag = 1'b0;
    end
    if (sw_cmd.buf_wr) begin
      s_next.buf_q = transfer_wdata;
      s_next.tx_shift = transfer_wdata;
      s_next.st.buffer_full_flag = 1'b1;
    end
    if (sw_cmd.irq_clr) begin
      s_next.st.port_irq_flag = 1'b0;
    end
    if (sw_cmd.ov_clr) begin
      s_next.st.receive_overflow_flag = 1'b0;
    end
    if (stop_seen) begin
      s_next.phase = PH_IDLE;
      s_next.hi_matched = 1'b0;
      s_next.ack_drive = 1'b0;
      s_next.nacked = 1'b0;
    end else if (start_seen) begin
      s_next.phase = PH_ADDR1;
      s_next.cnt = CNT_FIRST;
      s_next.ack_drive = 1'b0;
      s_next.nacked = 1'b0;
    end else if (live && scl_rise) begin
      if (s_reg.cnt < CNT_LAST_DATA) begin
        s_next.rx_shift = {s_reg.rx_shift[6:0], sda_s};
        s_next.cnt = s_reg.cnt + 4'h1;
      end else if (s_reg.cnt == CNT_LAST_DATA) begin
        s_next.cnt = CNT_NINTH;
        // The master's answer is taken on the ninth rising edge.
        if (s_reg.phase == PH_TX && sda_s) begin
          s_next.nacked = 1'b1;
          s_next.st.rw_status = 1'b0;
          s_next.st.update_address_flag = 1'b0;
          s_next.st.buffer_full_flag = 1'b0;
          s_next.hi_matched = 1'b0;
        end
      end
    end else if (byte_end) begin
      s_next.was_data = 1'b0;
      case (s_reg.phase)
        PH_ADDR1: begin
          if (addr_ok && !full) begin
            s_next.buf_q = s_reg.rx_shift;
            s_next.ack_drive = 1'b1;
            s_next.st.rw_status = s_reg.rx_shift[0];
            if (s_reg.rx_shift[0]) begin
              s_next.phase = PH_TX;
            end else begin
              s_next.st.buffer_full_flag = 1'b1;
              if (ten_bit_mode) begin
                s_next.st.update_address_flag = 1'b1;
                s_next.phase = PH_ADDR2;
              end else begin
                s_next.phase = PH_RX;
              end
            end
          end else begin
            s_next.phase = PH_IGNORE;
          end
        end
        PH_ADDR2: begin
          if (s_reg.rx_shift == own_address_register && !full) begin
            s_next.buf_q = s_reg.rx_shift;
            s_next.ack_drive = 1'b1;
            s_next.st.buffer_full_flag = 1'b1;
            s_next.st.update_address_flag = 1'b1;
            s_next.hi_matched = 1'b1;
            s_next.phase = PH_RX;
          end else begin
            s_next.phase = PH_IGNORE;
          end
        end
        PH_RX: begin
          s_next.was_data = 1'b1;
          if (full) begin
            if (s_reg.st.buffer_full_flag) begin
              s_next.st.receive_overflow_flag = 1'b1;
            end
          end else begin
            s_next.buf_q = s_reg.rx_shift;
            s_next.ack_drive = 1'b1;
            s_next.st.buffer_full_flag = 1'b1;
          end
        end
        PH_TX: begin
          s_next.was_data = 1'b1;
          // A buffer write in the same cycle keeps its full flag.
          if (!sw_cmd.buf_wr) begin
            s_next.st.buffer_full_flag = 1'b0;
          end
        end
        default: begin
          s_next.phase = PH_IGNORE;
        end
      endcase
    end else if (ninth_end) begin
      s_next.cnt = CNT_FIRST;
      s_next.ack_drive = 1'b0;
      s_next.st.port_irq_flag = 1'b1;
      if (s_reg.nacked) begin
        s_next.phase = PH_IGNORE;
        s_next.nacked = 1'b0;
      end else if (s_reg.phase == PH_TX) begin
        if (!s_next.st.buffer_full_flag) begin
          s_next.st.clock_release_bit = 1'b0;
        end
      end else if (s_reg.was_data) begin
        if (receive_stretch_enable && s_next.st.buffer_full_flag) begin
          s_next.st.clock_release_bit = 1'b0;
        end
      end else if (s_next.st.update_address_flag) begin
        s_next.ua_hold = 1'b1;
      end
    end else if (live && scl_fall && s_reg.phase == PH_TX &&
        s_reg.cnt != CNT_FIRST) begin
      s_next.tx_shift = {s_reg.tx_shift[6:0], 1'b1};
    end
    if (sw_cmd.ckp_set) begin
      s_next.st.clock_release_bit = 1'b1;
    end
    hold_req = !s_next.st.clock_release_bit || s_next.ua_hold;
    // The hold starts only once the master has pulled the line low.
    s_next.scl_hold = hold_req && (s_reg.scl_hold || !scl_s);
    // The last bit stays out until the eighth falling edge.
    s_next.sda_hold = s_next.ack_drive ||
      (s_next.phase == PH_TX && !s_next.nacked && !s_next.tx_shift[7] &&
      (s_next.cnt < CNT_LAST_DATA ||
      (s_next.cnt == CNT_LAST_DATA && scl_s)));
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_reg <= STATE_RESET;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // Pads only ever pull low; the pull-up makes the high level.
  assign scl_drive.out = 1'b0;
  assign scl_drive.oe = s_reg.scl_hold;
  assign sda_drive.out = 1'b0;
  assign sda_drive.oe = s_reg.sda_hold;
  assign transfer_buffer = s_reg.buf_q;
  assign port_status_register = s_reg.st;

  default clocking cb @(posedge clk_sys);
  endclocking

  default disable iff (sys_rst);

  sequence s_addr_wr_ok;
    byte_end && s_reg.phase == PH_ADDR1 && !ten_bit_mode && match7 &&
      !s_reg.rx_shift[0] && !full;
  endsequence

  sequence s_addr_rd_ok;
    byte_end && s_reg.phase == PH_ADDR1 && addr_ok &&
      s_reg.rx_shift[0] && !full;
  endsequence

  sequence s_master_nack;
    clk_en && live && scl_rise && !stop_seen && !start_seen &&
      s_reg.cnt == CNT_LAST_DATA && s_reg.phase == PH_TX && sda_s;
  endsequence

  sequence s_tx_ninth;
    ninth_end && s_reg.phase == PH_TX && !s_reg.nacked;
  endsequence

  sequence s_rd_addr_ninth;
    ninth_end && s_reg.phase == PH_TX && !s_reg.was_data && !s_reg.nacked;
  endsequence

  write_ack_a: assert property (
    s_addr_wr_ok |=> sda_drive.oe && !port_status_register.rw_status &&
      port_status_register.buffer_full_flag)
    else $error("write address not acknowledged or buffered");

  full_nack_a: assert property (
    byte_end && s_reg.phase != PH_TX && full |=> !sda_drive.oe)
    else $error("acknowledge given while buffer full or overflow");

  irq_sticky_a: assert property (
    port_status_register.port_irq_flag && !sw_cmd.irq_clr
      |=> port_status_register.port_irq_flag)
    else $error("interrupt flag dropped without software clear");

  rx_stretch_a: assert property (
    ninth_end && s_reg.phase == PH_RX && s_reg.was_data &&
      receive_stretch_enable && s_reg.st.buffer_full_flag &&
      !sw_cmd.buf_rd && !sw_cmd.ckp_set
      |=> !port_status_register.clock_release_bit ##2 scl_drive.oe)
    else $error("full receive buffer did not stretch the clock");

  rx_free_a: assert property (
    ninth_end && s_reg.phase == PH_RX && s_reg.st.clock_release_bit &&
      !s_reg.st.buffer_full_flag && !sw_cmd.buf_wr && !s_reg.ua_hold
      |=> port_status_register.clock_release_bit && !scl_drive.oe)
    else $error("clock stretched with empty receive buffer");

  read_addr_a: assert property (
    s_addr_rd_ok |=> port_status_register.rw_status && sda_drive.oe &&
      transfer_buffer == $past(s_reg.rx_shift))
    else $error("read address not acknowledged or buffered");

  read_hold_a: assert property (
    s_rd_addr_ninth ##0 (!s_reg.st.buffer_full_flag && !sw_cmd.buf_wr &&
      !sw_cmd.ckp_set) |=> port_status_register.rw_status &&
      !port_status_register.clock_release_bit && scl_drive.oe)
    else $error("read address did not hold the clock");

  addr_keep_a: assert property (
    ninth_end && s_reg.phase != PH_TX && !s_reg.was_data && !sw_cmd.ckp_set
      |=> port_status_register.clock_release_bit ==
      $past(port_status_register.clock_release_bit))
    else $error("address byte changed the release bit");

  tx_load_a: assert property (
    clk_en && sw_cmd.buf_wr && !scl_fall
      |=> s_reg.tx_shift == $past(transfer_wdata))
    else $error("buffer write did not load the shift register");

  tx_edge_a: assert property (
    $changed(sda_drive.oe) && !$past(sw_cmd.buf_wr) |-> !scl_s)
    else $error("data line changed while clock high");

  nack_reset_a: assert property (
    s_master_nack |=> !port_status_register.rw_status &&
      !port_status_register.buffer_full_flag && s_reg.nacked)
    else $error("not-acknowledge did not reset the slave status");

  tx_irq_a: assert property (
    s_tx_ninth |=> port_status_register.port_irq_flag)
    else $error("no interrupt at ninth falling edge in transmit");

  tx_stretch_a: assert property (
    s_tx_ninth ##0 (!s_reg.st.buffer_full_flag && !sw_cmd.buf_wr &&
      !sw_cmd.ckp_set) |=> !port_status_register.clock_release_bit)
    else $error("empty transmit buffer did not clear the release bit");

  ua_hold_a: assert property (
    ninth_end && s_reg.phase == PH_RX && !s_reg.was_data &&
      s_reg.st.update_address_flag && !sw_cmd.addr_wr && !sw_cmd.ckp_set
      |=> s_reg.ua_hold && scl_drive.oe &&
      port_status_register.clock_release_bit ==
      $past(port_status_register.clock_release_bit))
    else $error("update flag did not hold the clock");

  scl_late_a: assert property (
    $rose(scl_drive.oe) |-> !$past(scl_s))
    else $error("clock pulled low before the master pulled it");

  scl_keep_a: assert property (
    scl_drive.oe && !port_status_register.clock_release_bit &&
      !sw_cmd.ckp_set |=> scl_drive.oe)
    else $error("clock released before the release bit was set");

endmodule

/* File: sim/issrt_master.sv */
// Behavioural two-wire bus master driving the slave path from the far side.
// Assumes open-drain lines: the bench forms each line as a wired-AND.
`timescale 1ns/1ps
module issrt_master (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_m,
  output logic sda_m,
  output logic stall_tmo
);
  localparam realtime Q = 31.25;

  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    stall_tmo = 1'b0;
  end

  // Releases the clock and waits while another device still holds it low.
  task automatic rel_scl();
    int n;
    n = 0;
    scl_m = 1'b1;
    while (scl_line !== 1'b1 && n < 4000) begin
      #10;
      n++;
    end
    if (n >= 4000) stall_tmo = 1'b1;
  endtask

  task automatic bit_x(input logic b, output logic r);
    sda_m = b;
    #Q;
    rel_scl();
    #Q;
    r = sda_line;
    #Q;
    scl_m = 1'b0;
    #Q;
  endtask

  task automatic start_c();
    sda_m = 1'b1;
    #(2*Q);
    rel_scl();
    #Q;
    sda_m = 1'b0;
    #Q;
    scl_m = 1'b0;
    #Q;
  endtask

  task automatic stop_c();
    sda_m = 1'b0;
    #Q;
    rel_scl();
    #Q;
    sda_m = 1'b1;
    #(2*Q);
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(ack_in, ack_out);
  endtask
endmodule

/* File: sim/issrt_slave_bench.sv */
// Self-checking bench for the slave path against a behavioural bus master.
// Assumes a 100 MHz system clock; the bus runs at a 125 ns clock period.
`timescale 1ns/1ps
module issrt_slave_bench;
  import issrt_pkg::*;
  localparam issrt_cmd_type C_ADDR = 6'h20;
  localparam issrt_cmd_type C_WR = 6'h10;
  localparam issrt_cmd_type C_RD = 6'h08;
  localparam issrt_cmd_type C_CKP = 6'h04;
  localparam issrt_cmd_type C_IRQ = 6'h02;
  localparam issrt_cmd_type C_OV = 6'h01;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic ten_bit_mode = 1'b0;
  logic receive_stretch_enable = 1'b0;
  logic [7:0] own_address_register = 8'h74;
  logic [7:0] transfer_wdata = 8'h00;
  issrt_cmd_type sw_cmd = '0;
  issrt_od_type scl_drive;
  issrt_od_type sda_drive;
  logic [7:0] transfer_buffer;
  issrt_status_type st;
  logic scl_m, sda_m, stall_tmo, scl_line, sda_line, a;
  logic [7:0] r;
  int mismatches = 0;
  int checks_done = 0;

  assign scl_line = scl_m & ~scl_drive.oe;
  assign sda_line = sda_m & ~sda_drive.oe;
  always #5 clk_sys = ~clk_sys;

  issrt_slave issrt_slave_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clk_en(1'b1), .scl_pin(scl_line), .sda_pin(sda_line),
    .scl_drive(scl_drive), .sda_drive(sda_drive),
    .ten_bit_mode(ten_bit_mode),
    .receive_stretch_enable(receive_stretch_enable),
    .own_address_register(own_address_register),
    .transfer_wdata(transfer_wdata), .sw_cmd(sw_cmd),
    .transfer_buffer(transfer_buffer), .port_status_register(st));
  issrt_master issrt_master_i (.scl_line(scl_line), .sda_line(sda_line),
    .scl_m(scl_m), .sda_m(sda_m), .stall_tmo(stall_tmo));

  task automatic end_sim();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input issrt_cmd_type c);
    @(negedge clk_sys);
    sw_cmd = c;
    @(negedge clk_sys);
    sw_cmd = '0;
  endtask

  task automatic settle();
    repeat (8) @(negedge clk_sys);
  endtask

  // Sends one byte from the master and lets the slave's answer land.
  task automatic wb(input logic [7:0] b);
    issrt_master_i.xfer(b, 1'b1, r, a);
    settle();
  endtask

  task automatic wait_bf(input logic v);
    int n;
    n = 0;
    while (st.buffer_full_flag !== v && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 300) begin
      mismatches++;
      end_sim();
    end
  endtask

  task automatic t_reset();
    chk_bit(scl_drive.oe, 1'b0);
    chk_bit(sda_drive.oe, 1'b0);
    chk_byte(transfer_buffer, 8'h00);
    chk_byte({2'b00, st}, 8'h01);
  endtask

  task automatic t_rx7();
    issrt_master_i.start_c();
    wb(8'h74);
    chk_bit(a, 1'b0);
    chk_byte(transfer_buffer, 8'h74);
    chk_bit(st.rw_status, 1'b0);
    repeat (20) @(negedge clk_sys);
    chk_bit(st.port_irq_flag, 1'b1);
    chk_bit(st.clock_release_bit, 1'b1);
    cmd(C_IRQ | C_RD);
    chk_bit(st.port_irq_flag, 1'b0);
    receive_stretch_enable = 1'b1;
    wb(8'h5c);
    chk_byte(transfer_buffer, 8'h5c);
    chk_bit(st.clock_release_bit, 1'b0);
    chk_bit(scl_drive.oe, 1'b1);
    cmd(C_RD);
    chk_bit(scl_drive.oe, 1'b1);
    cmd(C_CKP);
    settle();
    chk_bit(scl_drive.oe, 1'b0);
    fork
      wb(8'h3c);
      begin
        wait_bf(1'b1);
        cmd(C_RD);
      end
    join
    chk_bit(st.clock_release_bit, 1'b1);
    chk_bit(scl_drive.oe, 1'b0);
    receive_stretch_enable = 1'b0;
    wb(8'h11);
    wb(8'h22);
    chk_bit(a, 1'b1);
    chk_bit(st.receive_overflow_flag, 1'b1);
    issrt_master_i.start_c();
    wb(8'h74);
    chk_bit(a, 1'b1);
    cmd(C_RD | C_IRQ);
    issrt_master_i.start_c();
    wb(8'h74);
    chk_bit(a, 1'b1);
    issrt_master_i.stop_c();
    cmd(C_OV);
  endtask

  task automatic t_tx7();
    issrt_master_i.start_c();
    wb(8'h75);
    chk_bit(a, 1'b0);
    chk_bit(st.rw_status, 1'b1);
    chk_byte(transfer_buffer, 8'h75);
    chk_bit(scl_drive.oe, 1'b1);
    transfer_wdata = 8'ha5;
    cmd(C_WR | C_IRQ);
    chk_bit(st.buffer_full_flag, 1'b1);
    cmd(C_CKP);
    issrt_master_i.xfer(8'hff, 1'b0, r, a);
    chk_byte(r, 8'ha5);
    settle();
    chk_bit(st.port_irq_flag, 1'b1);
    chk_bit(st.clock_release_bit, 1'b0);
    chk_bit(scl_drive.oe, 1'b1);
    transfer_wdata = 8'h3c;
    cmd(C_WR | C_IRQ);
    cmd(C_CKP);
    fork
      issrt_master_i.xfer(8'hff, 1'b0, r, a);
      begin
        wait_bf(1'b0);
        transfer_wdata = 8'hc3;
        cmd(C_WR);
      end
    join
    chk_byte(r, 8'h3c);
    settle();
    chk_bit(st.clock_release_bit, 1'b1);
    chk_bit(scl_drive.oe, 1'b0);
    issrt_master_i.xfer(8'hff, 1'b1, r, a);
    chk_byte(r, 8'hc3);
    settle();
    chk_bit(st.rw_status, 1'b0);
    chk_bit(st.buffer_full_flag, 1'b0);
    chk_bit(st.port_irq_flag, 1'b1);
    issrt_master_i.stop_c();
    cmd(C_IRQ);
  endtask

  task automatic t_ten();
    ten_bit_mode = 1'b1;
    receive_stretch_enable = 1'b1;
    own_address_register = 8'hf2;
    issrt_master_i.start_c();
    wb(8'hf2);
    chk_bit(a, 1'b0);
    chk_bit(st.update_address_flag, 1'b1);
    chk_bit(scl_drive.oe, 1'b1);
    chk_bit(st.clock_release_bit, 1'b1);
    own_address_register = 8'h9b;
    cmd(C_ADDR | C_RD | C_IRQ);
    settle();
    chk_bit(st.update_address_flag, 1'b0);
    chk_bit(scl_drive.oe, 1'b0);
    wb(8'h9b);
    chk_bit(a, 1'b0);
    chk_bit(st.update_address_flag, 1'b1);
    chk_bit(scl_drive.oe, 1'b1);
    chk_bit(st.clock_release_bit, 1'b1);
    receive_stretch_enable = 1'b0;
    own_address_register = 8'hf2;
    cmd(C_ADDR | C_RD | C_IRQ);
    wb(8'h66);
    chk_byte(transfer_buffer, 8'h66);
    cmd(C_RD);
    issrt_master_i.start_c();
    wb(8'hf3);
    chk_bit(a, 1'b0);
    chk_bit(st.update_address_flag, 1'b0);
    chk_bit(st.rw_status, 1'b1);
    chk_bit(st.clock_release_bit, 1'b0);
    transfer_wdata = 8'h81;
    cmd(C_WR);
    cmd(C_CKP);
    issrt_master_i.xfer(8'hff, 1'b1, r, a);
    chk_byte(r, 8'h81);
    issrt_master_i.stop_c();
  endtask

  always @(posedge stall_tmo) begin
    mismatches++;
    end_sim();
  end

  initial begin
    #900000;
    mismatches++;
    end_sim();
  end

  initial begin
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    t_reset();
    t_rx7();
    t_tx7();
    t_ten();
    end_sim();
  end
endmodule
